// ### src/mrcm_mapper.sv
// Notes on behaviour
// - select 0 regulates velocity to reference
// - select 1 regulates torque current instead
// - source select picks analog, PWM, serial, frequency
// - analog: zero below entry, linear, clamped
// - PWM: follows duty, zero at entry threshold
// - rate band sets accepted PWM frequency range
// - serial mode: command taken from serial register
// - serial: sleep after long zero, pin low
// - serial: pin above exit leaves sleep
// - serial: standby while register low, pin high
// - frequency: zero below entry, linear, clamped
// - direct curve: target is command times full scale
// - direct curve: small changes leave target unchanged
// - zero command always stops the motor
// - shaped target is level/255 times full scale
// - linear curve: piecewise between clamp levels
// - lower off level with on/off hysteresis
// - hold lower clamp, then ramp through A..E
// - ramp E to upper clamp, then hold
// - upper off level with on/off hysteresis
`timescale 1ns/1ps
`default_nettype none
module mrcm_mapper #(
	parameter int W = 16
) (
	input	wire logic			clk_sys,
	input	wire logic			nrst,
	input	wire logic			closed_loop_target_select,
	input	wire logic [1:0]		source_select,
	input	wire logic [1:0]		curve_select,
	input	wire logic [1:0]		rate_band,
	input	wire logic [W-1:0]		analog_level,
	input	wire logic			cmd_pin,
	input	wire logic [7:0]		serial_cmd,
	input	wire logic [W-1:0]		sb_entry_level,
	input	wire logic [W-1:0]		sb_exit_level,
	input	wire logic [W-1:0]		full_scale_level,
	input	wire logic [7:0]		duty_sb_entry,
	input	wire logic [7:0]		duty_sb_exit,
	input	wire logic [7:0]		serial_sb_level,
	input	wire logic [W-1:0]		sleep_entry_level,
	input	wire logic [W-1:0]		sleep_exit_level,
	input	wire logic [W-1:0]		sleep_entry_delay_us,
	input	wire logic [W-1:0]		full_scale_velocity,
	input	wire logic [W-1:0]		full_scale_current,
	input	wire logic [7:0]		command_deadband,
	input	wire logic [7:0]		lower_off_breakpoint,
	input	wire logic [7:0]		lower_on_breakpoint,
	input	wire logic [7:0]		lower_clamp_breakpoint,
	input	wire logic [4:0][7:0]		cmd_breakpoints,
	input	wire logic [7:0]		upper_clamp_breakpoint,
	input	wire logic [7:0]		upper_on_breakpoint,
	input	wire logic [7:0]		upper_off_breakpoint,
	input	wire logic [7:0]		lower_off_level,
	input	wire logic [7:0]		lower_clamp_level,
	input	wire logic [4:0][7:0]		point_levels,
	input	wire logic [7:0]		upper_clamp_level,
	input	wire logic [7:0]		upper_off_level,
	output	logic [W-1:0]			velocity_target,
	output	logic [W-1:0]			current_target,
	output	logic				loop_mode,
	output	logic [7:0]			norm_command,
	output	logic				standby,
	output	logic				sleep,
	output	logic				target_update
);
	import mrcm_pkg::*;

	localparam logic [W-1:0] WMAX = {W{1'b1}};
	localparam logic [7:0] US_LAST = 8'(US_TICK_CYCLES - 1);
	localparam logic [W-1:0] GATE_LAST = W'(GATE_TIME_US - 1);

	mrcm_state_t		state_reg;
	logic [7:0]		us_cnt_reg;
	logic [5:0]		pre_cnt_reg;
	logic			pin_d_reg;
	logic [W-1:0]		hi_cnt_reg, per_cnt_reg, hi_lat_reg, per_lat_reg;
	logic [W-1:0]		gate_cnt_reg, edge_cnt_reg, freq_lat_reg;
	logic [W-1:0]		zero_us_reg;
	logic			sleep_reg, sb_reg, lo_off_reg, up_off_reg;
	logic [W-1:0]		x_reg;
	logic			x_zero_reg;
	logic [7:0]		norm_reg, held_reg, level_reg, norm_out_reg;
	logic			down_reg;
	logic [7:0]		base_reg;
	logic [31:0]		a_num_reg;
	logic [W-1:0]		a_den_reg;
	logic			div_go_reg;
	logic [31:0]		sh_reg, q_reg;
	logic [W:0]		rem_reg;
	logic [5:0]		div_cnt_reg;
	logic			div_done_reg;
	logic [W-1:0]		vel_reg, cur_reg;
	logic			loop_reg, upd_reg;
	logic			us_tick, pre_tick, rise;
	logic [5:0]		pre_lim;
	logic [W-1:0]		x_c, ex_c, fs_c;
	logic [W:0]		rem_s;
	logic [7:0]		nq;
	logic [7:0]		x0, x1, y0, y1, px, py;
	logic			found, flat, stop_c;

	assign us_tick = (us_cnt_reg == US_LAST);
	// wider bands slow the duty sampler so longer PWM periods still fit the counters
	assign pre_lim = 6'((6'h01 << {rate_band, 1'b0}) - 6'h01);
	assign pre_tick = (pre_cnt_reg == pre_lim);
	assign rise = cmd_pin & ~pin_d_reg;

	// microsecond enable and duty-sampling prescaler
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			us_cnt_reg <= 8'h00;
			pre_cnt_reg <= 6'h00;
		end else begin
			us_cnt_reg <= us_tick ? 8'h00 : us_cnt_reg + 8'h01;
			pre_cnt_reg <= pre_tick ? 6'h00 : pre_cnt_reg + 6'h01;
		end
	end

	// high time and period of the command pin, latched at each rising edge
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			pin_d_reg <= 1'b0;
			hi_cnt_reg <= '0;
			per_cnt_reg <= '0;
			hi_lat_reg <= '0;
			per_lat_reg <= '0;
		end else begin
			pin_d_reg <= cmd_pin;
			if (rise) begin
				hi_lat_reg <= hi_cnt_reg;
				per_lat_reg <= per_cnt_reg;
				// the edge cycle itself is high and part of the new period; skipping it loses one count
				hi_cnt_reg <= pre_tick ? W'(1) : '0;
				per_cnt_reg <= pre_tick ? W'(1) : '0;
			end else if (pre_tick) begin
				if (per_cnt_reg == WMAX) begin
					// steady pin: report 0% or 100% duty
					per_lat_reg <= WMAX;
					hi_lat_reg <= cmd_pin ? WMAX : '0;
				end else begin
					per_cnt_reg <= per_cnt_reg + 1'b1;
					if (cmd_pin)
						hi_cnt_reg <= hi_cnt_reg + 1'b1;
				end
			end
		end
	end

	// rising edges counted over a fixed gate give the input frequency
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			gate_cnt_reg <= '0;
			edge_cnt_reg <= '0;
			freq_lat_reg <= '0;
		end else if (us_tick && gate_cnt_reg == GATE_LAST) begin
			gate_cnt_reg <= '0;
			freq_lat_reg <= edge_cnt_reg;
			edge_cnt_reg <= rise ? W'(1) : '0;
		end else begin
			if (us_tick)
				gate_cnt_reg <= gate_cnt_reg + 1'b1;
			if (rise && edge_cnt_reg != WMAX)
				edge_cnt_reg <= edge_cnt_reg + 1'b1;
		end
	end

	// raw value, linear origin and full scale of the chosen source
	always_comb begin
		x_c = analog_level;
		ex_c = sb_exit_level;
		fs_c = full_scale_level;
		case (source_select)
			SRC_PWM: begin
				x_c = hi_lat_reg;
				ex_c = '0;
				fs_c = per_lat_reg;
			end
			SRC_SERIAL: begin
				x_c = W'(serial_cmd);
				ex_c = '0;
				fs_c = W'(FULL_LEVEL);
			end
			SRC_FREQ: x_c = freq_lat_reg;
			default: x_c = analog_level;
		endcase
	end

	// serial mode sleep: long zero register plus low pin enters, high pin leaves
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			zero_us_reg <= '0;
			sleep_reg <= 1'b0;
		end else if (source_select != SRC_SERIAL) begin
			zero_us_reg <= '0;
			sleep_reg <= 1'b0;
		end else begin
			if (serial_cmd != 8'h00)
				zero_us_reg <= '0;
			else if (us_tick && zero_us_reg != WMAX)
				zero_us_reg <= zero_us_reg + 1'b1;
			if (analog_level > sleep_exit_level)
				sleep_reg <= 1'b0;
			else if (zero_us_reg > sleep_entry_delay_us && analog_level < sleep_entry_level)
				sleep_reg <= 1'b1;
		end
	end

	// standby and curve hysteresis, judged on each fresh normalized command
	assign nq = mrcm_clamp8(q_reg);
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			sb_reg <= 1'b1;
			lo_off_reg <= 1'b1;
			up_off_reg <= 1'b0;
		end else if (state_reg == ST_NORM && div_done_reg) begin
			case (source_select)
				SRC_PWM: begin
					if (nq <= duty_sb_entry)
						sb_reg <= 1'b1;
					else if (nq >= duty_sb_exit)
						sb_reg <= 1'b0;
				end
				SRC_SERIAL: sb_reg <= (nq <= serial_sb_level) && (analog_level > sleep_exit_level);
				default: begin
					if (x_reg <= sb_entry_level)
						sb_reg <= 1'b1;
					else if (x_reg >= sb_exit_level)
						sb_reg <= 1'b0;
				end
			endcase
			if (nq < lower_off_breakpoint)
				lo_off_reg <= 1'b1;
			else if (nq >= lower_on_breakpoint)
				lo_off_reg <= 1'b0;
			if (nq > upper_off_breakpoint)
				up_off_reg <= 1'b1;
			else if (nq < upper_on_breakpoint)
				up_off_reg <= 1'b0;
		end
	end

	// segment of the linear curve holding the command
	always_comb begin
		x0 = 8'h00;
		x1 = 8'h00;
		y0 = upper_clamp_level;
		y1 = upper_clamp_level;
		px = lower_clamp_breakpoint;
		py = lower_clamp_level;
		found = 1'b0;
		if (lo_off_reg) begin
			y0 = lower_off_level;
			found = 1'b1;
		end else if (up_off_reg) begin
			y0 = upper_off_level;
			found = 1'b1;
		end else if (norm_reg <= lower_clamp_breakpoint) begin
			y0 = lower_clamp_level;
			found = 1'b1;
		end
		for (int i = 0; i < 5; i++) begin
			if (!found && norm_reg <= cmd_breakpoints[i]) begin
				x0 = px;
				x1 = cmd_breakpoints[i];
				y0 = py;
				y1 = point_levels[i];
				found = 1'b1;
			end
			px = cmd_breakpoints[i];
			py = point_levels[i];
		end
		if (!found && norm_reg <= upper_clamp_breakpoint) begin
			x0 = px;
			x1 = upper_clamp_breakpoint;
			y0 = py;
			y1 = upper_clamp_level;
		end
		y1 = found && x1 == 8'h00 ? y0 : y1;
		flat = (x1 <= x0) || (y0 == y1);
	end

	// zero command, standby and sleep all force a stopped motor
	assign stop_c = x_zero_reg || sb_reg || sleep_reg;

	// sequencer: normalize, pick level, interpolate, scale; loops forever
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			state_reg <= ST_IDLE;
			div_go_reg <= 1'b0;
			a_num_reg <= '0;
			a_den_reg <= '0;
			x_reg <= '0;
			x_zero_reg <= 1'b1;
			norm_reg <= RST_LEVEL;
			held_reg <= RST_LEVEL;
			level_reg <= RST_LEVEL;
			base_reg <= RST_LEVEL;
			down_reg <= 1'b0;
		end else begin
			div_go_reg <= 1'b0;
			case (state_reg)
				ST_IDLE: begin
					// live settings are re-read on every pass
					x_reg <= x_c;
					x_zero_reg <= (x_c == '0);
					a_num_reg <= (x_c > ex_c) ? 32'(x_c - ex_c) * 32'(FULL_LEVEL) : '0;
					a_den_reg <= (x_c >= fs_c) ? W'(1) : fs_c - ex_c;
					div_go_reg <= 1'b1;
					state_reg <= ST_NORM;
				end
				ST_NORM: begin
					if (div_done_reg) begin
						norm_reg <= (x_reg >= fs_c) ? FULL_LEVEL : nq;
						state_reg <= ST_PICK;
					end
				end
				ST_PICK: begin
					state_reg <= ST_LOAD;
					if (stop_c)
						level_reg <= RST_LEVEL;
					else if (curve_select == CURVE_LINEAR) begin
						level_reg <= y0;
						if (!flat) begin
							base_reg <= y0;
							down_reg <= (y1 < y0);
							a_num_reg <= 32'(norm_reg - x0) * 32'(mrcm_absdiff(y1, y0));
							a_den_reg <= W'(x1 - x0);
							div_go_reg <= 1'b1;
							state_reg <= ST_MAP;
						end
					end else if (mrcm_absdiff(norm_reg, held_reg) >= command_deadband) begin
						held_reg <= norm_reg;
						level_reg <= norm_reg;
					end else
						level_reg <= held_reg;
				end
				ST_MAP: begin
					if (div_done_reg) begin
						if (down_reg)
							level_reg <= (q_reg > 32'(base_reg)) ? 8'h00 : base_reg - q_reg[7:0];
						else
							level_reg <= mrcm_clamp8(32'(base_reg) + q_reg);
						state_reg <= ST_LOAD;
					end
				end
				ST_LOAD: begin
					a_num_reg <= 32'(level_reg) * 32'(closed_loop_target_select ? full_scale_current
						: full_scale_velocity);
					a_den_reg <= W'(FULL_LEVEL);
					div_go_reg <= 1'b1;
					state_reg <= ST_SCALE;
				end
				ST_SCALE: begin
					if (div_done_reg)
						state_reg <= ST_IDLE;
				end
				default: state_reg <= ST_IDLE;
			endcase
		end
	end

	// shared restoring divider, one quotient bit per cycle
	assign rem_s = {rem_reg[W-1:0], sh_reg[31]};
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			sh_reg <= '0;
			q_reg <= '0;
			rem_reg <= '0;
			div_cnt_reg <= 6'h00;
			div_done_reg <= 1'b0;
		end else begin
			div_done_reg <= (div_cnt_reg == 6'h01);
			if (div_go_reg) begin
				sh_reg <= a_num_reg;
				q_reg <= '0;
				rem_reg <= '0;
				div_cnt_reg <= DIV_STEPS;
			end else if (div_cnt_reg != 6'h00) begin
				sh_reg <= {sh_reg[30:0], 1'b0};
				div_cnt_reg <= div_cnt_reg - 6'h01;
				if (rem_s >= {1'b0, a_den_reg}) begin
					rem_reg <= rem_s - {1'b0, a_den_reg};
					q_reg <= {q_reg[30:0], 1'b1};
				end else begin
					rem_reg <= rem_s;
					q_reg <= {q_reg[30:0], 1'b0};
				end
			end
		end
	end

	// result registers: only the selected loop's target is non-zero
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			vel_reg <= RST_TARGET;
			cur_reg <= RST_TARGET;
			loop_reg <= LOOP_VELOCITY;
			upd_reg <= 1'b0;
			norm_out_reg <= RST_LEVEL;
		end else begin
			upd_reg <= 1'b0;
			if (state_reg == ST_SCALE && div_done_reg) begin
				upd_reg <= 1'b1;
				loop_reg <= closed_loop_target_select;
				norm_out_reg <= stop_c ? RST_LEVEL : norm_reg;
				vel_reg <= closed_loop_target_select ? RST_TARGET : q_reg[W-1:0];
				cur_reg <= closed_loop_target_select ? q_reg[W-1:0] : RST_TARGET;
			end
		end
	end

	assign velocity_target = vel_reg;
	assign current_target = cur_reg;
	assign loop_mode = loop_reg;
	assign norm_command = norm_out_reg;
	assign standby = sb_reg;
	assign sleep = sleep_reg;
	assign target_update = upd_reg;

	sequence s_zero_out;
		upd_reg && vel_reg == '0 && cur_reg == '0;
	endsequence
	sequence s_pick_stop;
		state_reg == ST_PICK && stop_c;
	endsequence

	a_zero_stops: assert property (@(posedge clk_sys) disable iff (!nrst)
		s_pick_stop |-> ##[1:80] s_zero_out) else $error("stopped command gave non-zero target");
	a_loop_split: assert property (@(posedge clk_sys) disable iff (!nrst)
		upd_reg && loop_reg == LOOP_CURRENT |-> vel_reg == '0) else $error("velocity set in current mode");
	a_loop_curr: assert property (@(posedge clk_sys) disable iff (!nrst)
		upd_reg && loop_reg == LOOP_VELOCITY |-> cur_reg == '0) else $error("current set in velocity mode");
	a_sleep_exit: assert property (@(posedge clk_sys) disable iff (!nrst)
		analog_level > sleep_exit_level |=> !sleep_reg) else $error("sleep held with pin high");
	a_sleep_mode: assert property (@(posedge clk_sys) disable iff (!nrst)
		$rose(sleep_reg) |-> $past(zero_us_reg) > $past(sleep_entry_delay_us)) else $error("early sleep");
	a_lower_off: assert property (@(posedge clk_sys) disable iff (!nrst)
		state_reg == ST_PICK && !stop_c && curve_select == CURVE_LINEAR && lo_off_reg
		|=> level_reg == $past(lower_off_level)) else $error("lower off level not applied");
	a_upper_off: assert property (@(posedge clk_sys) disable iff (!nrst)
		state_reg == ST_PICK && !stop_c && curve_select == CURVE_LINEAR && !lo_off_reg && up_off_reg
		|=> level_reg == $past(upper_off_level)) else $error("upper off level not applied");
	a_deadband_hold: assert property (@(posedge clk_sys) disable iff (!nrst)
		state_reg == ST_PICK && !stop_c && curve_select == CURVE_DIRECT
		&& mrcm_absdiff(norm_reg, held_reg) < command_deadband
		|=> $stable(held_reg) && level_reg == held_reg) else $error("deadband change applied");
	a_norm_period: assert property (@(posedge clk_sys) disable iff (!nrst)
		state_reg == ST_IDLE |-> ##[71:105] upd_reg) else $error("target not refreshed");
endmodule
`default_nettype wire

// ### src/mrcm_pkg.sv
`default_nettype none
package mrcm_pkg;
	// core clock and the microsecond enable derived from it
	localparam int CLK_MHZ = 250;
	localparam int TICK_TIME_US = 1;
	localparam int US_TICK_CYCLES = TICK_TIME_US * CLK_MHZ;
	// frequency-mode gate window, counted in microsecond ticks
	localparam int GATE_TIME_US = 1000;
	// command origin codes
	localparam logic [1:0] SRC_ANALOG = 2'h0;
	localparam logic [1:0] SRC_PWM = 2'h1;
	localparam logic [1:0] SRC_SERIAL = 2'h2;
	localparam logic [1:0] SRC_FREQ = 2'h3;
	// transfer curve codes
	localparam logic [1:0] CURVE_DIRECT = 2'h0;
	localparam logic [1:0] CURVE_LINEAR = 2'h1;
	// closed-loop target codes
	localparam logic LOOP_VELOCITY = 1'b0;
	localparam logic LOOP_CURRENT = 1'b1;
	// full-scale normalized level and divider length
	localparam logic [7:0] FULL_LEVEL = 8'hFF;
	localparam logic [5:0] DIV_STEPS = 6'h20;
	localparam logic [15:0] RST_TARGET = 16'h0000;
	localparam logic [7:0] RST_LEVEL = 8'h00;

	typedef enum {ST_IDLE, ST_NORM, ST_PICK, ST_MAP, ST_LOAD, ST_SCALE} mrcm_state_t;

	// saturate a wide quotient to one byte
	function automatic logic [7:0] mrcm_clamp8(input logic [31:0] v);
		mrcm_clamp8 = (v > 32'(FULL_LEVEL)) ? FULL_LEVEL : v[7:0];
	endfunction

	// distance between two byte values
	function automatic logic [7:0] mrcm_absdiff(input logic [7:0] a, input logic [7:0] b);
		mrcm_absdiff = (a > b) ? a - b : b - a;
	endfunction
endpackage
`default_nettype wire

// ### testbench/mrcm_host_model.sv
`timescale 1ns/1ps
`default_nettype none
// host-side command source: drives the command pin as a PWM or square wave
module mrcm_host_model (
	input	wire logic		clk_sys,
	input	wire logic		nrst,
	input	wire logic		wave_on,
	input	wire logic [15:0]	wave_period,
	input	wire logic [15:0]	wave_high,
	output	logic			cmd_pin
);
	logic	[15:0]	phase_reg;

	// period counter, restarts whenever the wave is switched off
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			phase_reg <= 16'h0000;
		end else if (!wave_on || phase_reg >= wave_period - 16'h0001) begin
			phase_reg <= 16'h0000;
		end else begin
			phase_reg <= phase_reg + 16'h0001;
		end
	end

	// the pin idles low outside a wave and is registered high while phase_reg is below wave_high
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			cmd_pin <= 1'b0;
		end else begin
			cmd_pin <= wave_on && (phase_reg < wave_high);
		end
	end
endmodule
`default_nettype wire

// ### testbench/motor_reference_command_mapper_test.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) begin checks++; if ((got) !== (exp)) begin fails++; $display("mismatch at %0t: got %h, expected %h", $time, got, exp); end end
module motor_reference_command_mapper_test;
	import mrcm_pkg::*;

	typedef struct packed {
		logic [1:0]	src;
		logic [1:0]	curve;
		logic		loop;
		logic [15:0]	analog;
		logic [7:0]	serial;
		logic [7:0]	norm;
		logic [15:0]	target;
		logic		sb;
	} mrcm_row_t;

	logic			clk_sys = 1'b0;
	logic			nrst, closed_loop_target_select, cmd_pin, wave_on, loop_mode, standby, sleep, target_update;
	logic [1:0]		source_select, curve_select, rate_band;
	logic [15:0]		analog_level, sb_entry_level, sb_exit_level, full_scale_level, sleep_entry_level;
	logic [15:0]		sleep_exit_level, sleep_entry_delay_us, full_scale_velocity, full_scale_current;
	logic [15:0]		velocity_target, current_target, wave_period, wave_high;
	logic [7:0]		serial_cmd, duty_sb_entry, duty_sb_exit, serial_sb_level, command_deadband, norm_command;
	logic [7:0]		lower_off_breakpoint, lower_on_breakpoint, lower_clamp_breakpoint, upper_clamp_breakpoint;
	logic [7:0]		upper_on_breakpoint, upper_off_breakpoint, lower_off_level, lower_clamp_level;
	logic [7:0]		upper_clamp_level, upper_off_level;
	logic [4:0][7:0]	cmd_breakpoints, point_levels;
	int			fails = 0;
	int			checks = 0;
	int			cycles = 0;

	// ordinary cases; fs velocity 5100 and fs current 2550 make targets level*20 and level*10
	mrcm_row_t rows [19] = '{
		'{SRC_ANALOG, CURVE_DIRECT, LOOP_VELOCITY, 16'h02BC, 8'h00, 8'h7F, 16'h09EC, 1'b0},
		'{SRC_ANALOG, CURVE_DIRECT, LOOP_CURRENT, 16'h02BC, 8'h00, 8'h7F, 16'h04F6, 1'b0},
		'{SRC_ANALOG, CURVE_DIRECT, LOOP_VELOCITY, 16'h0514, 8'h00, 8'hFF, 16'h13EC, 1'b0},
		'{SRC_ANALOG, CURVE_DIRECT, LOOP_VELOCITY, 16'h0032, 8'h00, 8'h00, 16'h0000, 1'b1},
		'{SRC_SERIAL, CURVE_DIRECT, LOOP_VELOCITY, 16'h044C, 8'h80, 8'h80, 16'h0A00, 1'b0},
		'{SRC_SERIAL, 2'h2, LOOP_VELOCITY, 16'h044C, 8'h33, 8'h33, 16'h03FC, 1'b0},
		'{SRC_SERIAL, 2'h3, LOOP_CURRENT, 16'h044C, 8'hCC, 8'hCC, 16'h07F8, 1'b0},
		'{SRC_SERIAL, CURVE_LINEAR, LOOP_VELOCITY, 16'h044C, 8'h64, 8'h64, 16'h0708, 1'b0},
		'{SRC_SERIAL, CURVE_LINEAR, LOOP_VELOCITY, 16'h044C, 8'h23, 8'h23, 16'h0258, 1'b0},
		'{SRC_SERIAL, CURVE_LINEAR, LOOP_VELOCITY, 16'h044C, 8'h19, 8'h19, 16'h0258, 1'b0},
		'{SRC_SERIAL, CURVE_LINEAR, LOOP_VELOCITY, 16'h044C, 8'h0F, 8'h0F, 16'h0064, 1'b0},
		'{SRC_SERIAL, CURVE_LINEAR, LOOP_VELOCITY, 16'h044C, 8'h19, 8'h19, 16'h0064, 1'b0},
		'{SRC_SERIAL, CURVE_LINEAR, LOOP_VELOCITY, 16'h044C, 8'hD2, 8'hD2, 16'h0ED8, 1'b0},
		'{SRC_SERIAL, CURVE_LINEAR, LOOP_VELOCITY, 16'h044C, 8'hF5, 8'hF5, 16'h00C8, 1'b0},
		'{SRC_SERIAL, CURVE_LINEAR, LOOP_VELOCITY, 16'h044C, 8'hE6, 8'hE6, 16'h00C8, 1'b0},
		'{SRC_SERIAL, CURVE_LINEAR, LOOP_VELOCITY, 16'h044C, 8'hD7, 8'hD7, 16'h0ED8, 1'b0},
		'{SRC_SERIAL, CURVE_LINEAR, LOOP_VELOCITY, 16'h044C, 8'hB9, 8'hB9, 16'h0DAC, 1'b0},
		'{SRC_SERIAL, CURVE_LINEAR, LOOP_CURRENT, 16'h044C, 8'h64, 8'h64, 16'h0384, 1'b0},
		'{SRC_SERIAL, CURVE_LINEAR, LOOP_VELOCITY, 16'h044C, 8'h00, 8'h00, 16'h0000, 1'b1}
	};

	mrcm_mapper DUT (.clk_sys, .nrst, .closed_loop_target_select, .source_select, .curve_select, .rate_band,
		.analog_level, .cmd_pin, .serial_cmd, .sb_entry_level, .sb_exit_level, .full_scale_level,
		.duty_sb_entry, .duty_sb_exit, .serial_sb_level, .sleep_entry_level, .sleep_exit_level,
		.sleep_entry_delay_us, .full_scale_velocity, .full_scale_current, .command_deadband,
		.lower_off_breakpoint, .lower_on_breakpoint, .lower_clamp_breakpoint, .cmd_breakpoints,
		.upper_clamp_breakpoint, .upper_on_breakpoint, .upper_off_breakpoint, .lower_off_level,
		.lower_clamp_level, .point_levels, .upper_clamp_level, .upper_off_level, .velocity_target,
		.current_target, .loop_mode, .norm_command, .standby, .sleep, .target_update);

	mrcm_host_model host (.clk_sys, .nrst, .wave_on, .wave_period, .wave_high, .cmd_pin);

	// 250 MHz core clock
	always #2 clk_sys = ~clk_sys;

	task automatic stop_test();
		$display("checks %0d fails %0d", checks, fails);
		if (fails == 0 && checks > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	// the whole run needs about 55k cycles; a hang is cut off at 90k
	always @(posedge clk_sys) begin
		cycles++;
		if (cycles == 32'h00015F90) begin
			fails++;
			stop_test();
		end
	end

	// wait for n refresh pulses, sampled just after the edge so the pulse has landed
	task automatic wait_upd(input int n);
		int k;
		repeat (n) begin
			k = 0;
			@(posedge clk_sys);
			#1;
			while (target_update !== 1'b1 && k < 400) begin
				@(posedge clk_sys);
				#1;
				k++;
			end
			if (k >= 400) begin
				fails++;
				$display("mismatch at %0t: no target refresh", $time);
			end
		end
	endtask

	// two refreshes after a change: the pass in flight may still use the old command
	task automatic apply(input mrcm_row_t r, input bit full);
		@(posedge clk_sys);
		source_select <= r.src;
		curve_select <= r.curve;
		closed_loop_target_select <= r.loop;
		analog_level <= r.analog;
		serial_cmd <= r.serial;
		wait_upd(2);
		`CHK(loop_mode, r.loop)
		`CHK(r.loop ? current_target : velocity_target, r.target)
		if (full) begin
			`CHK(norm_command, r.norm)
			`CHK(standby, r.sb)
		end
	endtask

	initial begin
		int p;
		int k;
		nrst = 1'b0;
		closed_loop_target_select = LOOP_VELOCITY;
		{source_select, curve_select, rate_band} = 6'h00;
		{analog_level, serial_cmd, command_deadband} = 32'h00000000;
		{wave_on, wave_period, wave_high} = 33'h000000000;
		{sb_entry_level, sb_exit_level, full_scale_level} = {16'h0064, 16'h00C8, 16'h04B0};
		{duty_sb_entry, duty_sb_exit, serial_sb_level} = {8'h05, 8'h0A, 8'h0A};
		{sleep_entry_level, sleep_exit_level, sleep_entry_delay_us} = {16'h01F4, 16'h03E8, 16'h000A};
		{full_scale_velocity, full_scale_current} = {16'h13EC, 16'h09F6};
		// breakpoints ascend; every linear segment has slope one, level = command - 10
		{lower_off_breakpoint, lower_on_breakpoint, lower_clamp_breakpoint} = {8'h14, 8'h1E, 8'h28};
		cmd_breakpoints = {8'hB4, 8'h96, 8'h78, 8'h5A, 8'h3C};
		{upper_clamp_breakpoint, upper_on_breakpoint, upper_off_breakpoint} = {8'hC8, 8'hDC, 8'hF0};
		{lower_off_level, lower_clamp_level, upper_clamp_level, upper_off_level} = {8'h05, 8'h1E, 8'hBE, 8'h0A};
		point_levels = {8'hAA, 8'h8C, 8'h6E, 8'h50, 8'h32};
		repeat (8) @(posedge clk_sys);
		nrst <= 1'b1;
		foreach (rows[i]) begin
			apply(rows[i], 1'b1);
		end
		// deadband of 16: a step of 10 is held, a step of 16 applies
		@(posedge clk_sys);
		command_deadband <= 8'h10;
		apply('{SRC_SERIAL, CURVE_DIRECT, LOOP_VELOCITY, 16'h044C, 8'h64, 8'h64, 16'h07D0, 1'b0}, 1'b0);
		apply('{SRC_SERIAL, CURVE_DIRECT, LOOP_VELOCITY, 16'h044C, 8'h6E, 8'h6E, 16'h07D0, 1'b0}, 1'b0);
		apply('{SRC_SERIAL, CURVE_DIRECT, LOOP_VELOCITY, 16'h044C, 8'h74, 8'h74, 16'h0910, 1'b0}, 1'b0);
		// a full-scale change alone must reach the target
		@(posedge clk_sys);
		full_scale_velocity <= 16'h09F6;
		command_deadband <= 8'h00;
		wait_upd(2);
		`CHK(velocity_target, 16'h0488)
		// PWM duty 128/255 under prescale 1, 4, 16 and 64; periods stretch with the band
		for (int b = 0; b < 4; b++) begin
			p = 255 << (2 * b);
			@(posedge clk_sys);
			source_select <= SRC_PWM;
			rate_band <= 2'(b);
			wave_period <= 16'(p);
			wave_high <= 16'(128 << (2 * b));
			wave_on <= 1'b1;
			repeat (2 * p + 4) @(posedge clk_sys);
			wait_upd(2);
			`CHK(norm_command, 8'h80)
			`CHK(velocity_target, 16'h0500)
		end
		// duty 3/255 lies under the entry threshold of 5
		@(posedge clk_sys);
		rate_band <= 2'h0;
		wave_period <= 16'h00FF;
		wave_high <= 16'h0003;
		repeat (765) @(posedge clk_sys);
		wait_upd(2);
		`CHK(norm_command, 8'h00)
		`CHK(standby, 1'b1)
		@(posedge clk_sys);
		source_select <= SRC_FREQ;
		closed_loop_target_select <= LOOP_CURRENT;
		wait_upd(2);
		`CHK(loop_mode, LOOP_CURRENT)
		// no gate window has closed yet, so the measured rate is zero and the motor stays stopped
		`CHK(current_target, 16'h0000)
		`CHK(standby, 1'b1)
		// serial zero with the pin low: sleep after the 10 us delay, 2500 cycles
		@(posedge clk_sys);
		{source_select, curve_select, closed_loop_target_select} <= {SRC_SERIAL, CURVE_DIRECT, LOOP_VELOCITY};
		{wave_on, serial_cmd, analog_level} <= {1'b0, 8'h00, 16'h0190};
		k = 0;
		while (sleep !== 1'b1 && k < 4000) begin
			@(posedge clk_sys);
			#1;
			k++;
		end
		`CHK(k >= 2500 && k < 3000, 1'b1)
		@(posedge clk_sys);
		analog_level <= 16'h044C;
		wait_upd(2);
		`CHK(sleep, 1'b0)
		`CHK(standby, 1'b1)
		apply('{SRC_SERIAL, CURVE_DIRECT, LOOP_VELOCITY, 16'h044C, 8'h80, 8'h80, 16'h0500, 1'b0}, 1'b1);
		// second reset in mid-run, then recovery with the same command
		@(posedge clk_sys);
		nrst <= 1'b0;
		@(posedge clk_sys);
		#1;
		`CHK({velocity_target, current_target, norm_command}, 40'h0000000000)
		`CHK({standby, sleep, target_update, loop_mode}, 4'h8)
		@(posedge clk_sys);
		nrst <= 1'b1;
		wait_upd(2);
		`CHK(velocity_target, 16'h0500)
		stop_test();
	end
endmodule
`default_nettype wire
